// ### design/comm_cfg_pkg.sv
// How it works
// - Reaction 0: flag the error on the display, motor keeps running.
// - Reaction 1: flag the error and request a decelerate-to-stop.
// - Nonzero timeout up to 20 s raises the alarm after that much silence.
// - Timeout value zero turns timeout detection off entirely.
// - Node address is held within 0x0000 to 0x007F.
// - New node address never takes effect: restart clears it to 0, node reset is ignored at address 0.
// - Select bits 0 to 7 map onto digital inputs 1 to 8.
// - Select 0 takes the terminal, select 1 takes the software input bit.
// - Reply waits the programmed count of 0.5 ms units, 0 to 1000.
// - SYNC word holds error, target, dead zone, step; reset 0x5055.
// - Each clock correction moves at most the step field, 1 to F us.
// - Inside the dead zone the correction stays unchanged.
// - Target arrival time is 400 plus 10 times target field, us.
// - Profile function enable: 0 disables, 1 enables the packet function.
// - Status packet is four 16-bit words, each in its own register.
// - Control packet: mode word, 16-bit ref A, 32-bit ref B, mirrored.
// - Four 4-bit event masks; first three reset 0x1, fourth 0xF.
// - Software input register write sets inputs, read gives final inputs.
package comm_cfg_pkg;
    localparam logic [11:0] ADDR_REACTION = 12'h306;
    localparam logic [11:0] ADDR_TIMEOUT = 12'h308;
    localparam logic [11:0] ADDR_NODE = 12'h30A;
    localparam logic [11:0] ADDR_SRC_SEL = 12'h30C;
    localparam logic [11:0] ADDR_REPLY_DLY = 12'h30E;
    localparam logic [11:0] ADDR_SYNC_CFG = 12'h312;
    localparam logic [11:0] ADDR_PROFILE_EN = 12'h314;
    localparam logic [11:0] ADDR_STAT_W1 = 12'h316;
    localparam logic [11:0] ADDR_STAT_W2 = 12'h318;
    localparam logic [11:0] ADDR_STAT_W3 = 12'h31A;
    localparam logic [11:0] ADDR_STAT_W4 = 12'h31C;
    localparam logic [11:0] ADDR_CTRL_W1 = 12'h31E;
    localparam logic [11:0] ADDR_CTRL_W2 = 12'h320;
    localparam logic [11:0] ADDR_CTRL_W3 = 12'h322;
    localparam logic [11:0] ADDR_MASK1 = 12'h324;
    localparam logic [11:0] ADDR_MASK2 = 12'h326;
    localparam logic [11:0] ADDR_MASK3 = 12'h328;
    localparam logic [11:0] ADDR_MASK4 = 12'h32A;
    localparam logic [11:0] ADDR_SW_INPUT = 12'h40E;

    localparam logic [15:0] TIMEOUT_MAX = 16'h0014;
    localparam logic [15:0] NODE_MAX = 16'h007F;
    localparam logic [15:0] REPLY_DLY_MAX = 16'h03E8;
    localparam logic [15:0] SYNC_CFG_RST = 16'h5055;
    localparam logic [15:0] SYNC_CFG_MIN = 16'h1001;
    localparam logic [15:0] SYNC_CFG_MAX = 16'h9FFF;
    localparam logic [3:0] SYNC_E_MIN = 4'h1;
    localparam logic [3:0] SYNC_E_MAX = 4'h9;
    localparam logic [3:0] SYNC_T_MAX = 4'h9;
    localparam logic [3:0] SYNC_M_MIN = 4'h1;
    localparam logic [3:0] MASK_RST_LOW = 4'h1;
    localparam logic [3:0] MASK_RST_HIGH = 4'hF;
    localparam logic [15:0] TARGET_BASE_US = 16'h0190;
    localparam logic [15:0] TARGET_STEP_US = 16'h000A;
    localparam logic [15:0] ERR_UNIT_US = 16'h000A;

    localparam int CLK_HZ = 100000000;
    localparam int SECOND_CYCLES = CLK_HZ;
    localparam int HALF_MS_US = 500;
    localparam int HALF_MS_CYCLES = CLK_HZ / 1000000 * HALF_MS_US;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] err_range;
        logic [3:0] target;
        logic [3:0] dead_zone;
        logic [3:0] step;
    } sync_cfg_t;

    typedef struct packed {
        logic frame_valid;
        logic request_end;
        logic reply_ready;
    } link_evt_t;
endpackage

// ### design/comm_supervision_config.sv
`timescale 1ns/1ps
module comm_supervision_config #(
    parameter int SECOND_COUNT = comm_cfg_pkg::SECOND_CYCLES,
    parameter int HALF_MS_COUNT = comm_cfg_pkg::HALF_MS_CYCLES
) (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire comm_cfg_pkg::reg_req_t reg_req, // Parameter access
    output logic [31:0] reg_rdata, // Read data
    input wire comm_cfg_pkg::link_evt_t link_evt, // Frame events
    input wire logic node_reset_cmd, // Node reset network command
    input wire logic comm_error_in, // Other comm error detected
    input wire logic [7:0] terminal_inputs, // Terminal inputs, async
    input wire logic [15:0] sync_arrival_us, // Measured SYNC arrival
    input wire logic sync_arrival_valid, // New arrival sample
    input wire logic [3:0] pdo_event_src, // Event sources per object
    output logic [7:0] digital_inputs, // Resolved inputs 1 to 8
    output logic [6:0] active_node_address, // Node address in use
    output logic comm_error_alarm, // Error shown on display
    output logic stop_request, // Decelerate to stop
    output logic reply_start, // Start reply transmission
    output logic signed [4:0] clock_correction_us, // Per-SYNC correction
    output logic sync_locked, // Synchronised to master
    output logic profile_enable, // Profile packet function on
    output logic [3:0] pdo_trigger [4] // Per object trigger
);
    import comm_cfg_pkg::*;

    typedef enum logic [2:0] {
        RPL_IDLE = 3'b001,
        RPL_WAIT = 3'b010,
        RPL_GO = 3'b100
    } reply_state_t;

    logic [15:0] reaction_q;
    logic [15:0] timeout_q;
    logic [15:0] node_q;
    logic [15:0] src_sel_q;
    logic [15:0] reply_dly_q;
    sync_cfg_t sync_cfg_q;
    logic [15:0] profile_q;
    logic [15:0] stat_q [4];
    logic [15:0] ctrl1_q;
    logic [15:0] ctrl2_q;
    logic [31:0] ctrl3_q;
    logic [3:0] mask_q [4];
    logic [7:0] sw_in_q;
    logic [7:0] term_s1_q;
    logic [7:0] term_s2_q;
    logic [6:0] node_active_q;
    logic node_boot_q;
    logic [31:0] sec_div_q;
    logic [15:0] sec_cnt_q;
    logic timeout_hit;
    logic alarm_q;
    reply_state_t rpl_q;
    logic [31:0] tick_q;
    logic [15:0] units_q;
    logic [15:0] target_us;
    logic [15:0] diff_us;
    logic late;
    logic signed [4:0] corr_q;
    logic locked_q;
    logic [15:0] wd16;
    logic wr;

    // Every 16-bit setting travels in the lower half of the write data
    assign wd16 = reg_req.wdata[15:0];
    assign wr = reg_req.wr;

    // Configuration writes, out-of-range values are ignored
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            reaction_q <= 16'h0000;
            timeout_q <= 16'h0000;
            node_q <= 16'h0000;
            src_sel_q <= 16'h0000;
            reply_dly_q <= 16'h0000;
            sync_cfg_q <= SYNC_CFG_RST;
            profile_q <= 16'h0000;
        end
        else if (wr)
        begin
            if (reg_req.addr == ADDR_REACTION)
                reaction_q <= wd16;
            else if (reg_req.addr == ADDR_TIMEOUT && wd16 <= TIMEOUT_MAX)
                timeout_q <= wd16;
            else if (reg_req.addr == ADDR_NODE && wd16 <= NODE_MAX)
                node_q <= wd16;
            else if (reg_req.addr == ADDR_SRC_SEL)
                src_sel_q <= wd16;
            else if (reg_req.addr == ADDR_REPLY_DLY && wd16 <= REPLY_DLY_MAX)
                reply_dly_q <= wd16;
            else if (reg_req.addr == ADDR_SYNC_CFG && wd16 >= SYNC_CFG_MIN
                && wd16 <= SYNC_CFG_MAX && wd16[11:8] <= SYNC_T_MAX
                && wd16[15:12] >= SYNC_E_MIN && wd16[15:12] <= SYNC_E_MAX
                && wd16[3:0] >= SYNC_M_MIN)
                sync_cfg_q <= wd16;
            else if (reg_req.addr == ADDR_PROFILE_EN)
                profile_q <= wd16;
        end
    end

    // Packet mirror words
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 4; i++)
                stat_q[i] <= 16'h0000;
            ctrl1_q <= 16'h0000;
            ctrl2_q <= 16'h0000;
            ctrl3_q <= 32'h0000_0000;
        end
        else if (wr)
        begin
            if (reg_req.addr == ADDR_STAT_W1)
                stat_q[0] <= wd16;
            else if (reg_req.addr == ADDR_STAT_W2)
                stat_q[1] <= wd16;
            else if (reg_req.addr == ADDR_STAT_W3)
                stat_q[2] <= wd16;
            else if (reg_req.addr == ADDR_STAT_W4)
                stat_q[3] <= wd16;
            else if (reg_req.addr == ADDR_CTRL_W1)
                ctrl1_q <= wd16;
            else if (reg_req.addr == ADDR_CTRL_W2)
                ctrl2_q <= wd16;
            else if (reg_req.addr == ADDR_CTRL_W3)
                ctrl3_q <= reg_req.wdata;
        end
    end

    // Event masks and software inputs
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            mask_q[0] <= MASK_RST_LOW;
            mask_q[1] <= MASK_RST_LOW;
            mask_q[2] <= MASK_RST_LOW;
            mask_q[3] <= MASK_RST_HIGH;
            sw_in_q <= 8'h00;
        end
        else if (wr)
        begin
            if (reg_req.addr == ADDR_MASK1)
                mask_q[0] <= wd16[3:0];
            else if (reg_req.addr == ADDR_MASK2)
                mask_q[1] <= wd16[3:0];
            else if (reg_req.addr == ADDR_MASK3)
                mask_q[2] <= wd16[3:0];
            else if (reg_req.addr == ADDR_MASK4)
                mask_q[3] <= wd16[3:0];
            else if (reg_req.addr == ADDR_SW_INPUT)
                sw_in_q <= wd16[7:0];
        end
    end

    // Terminal inputs cross in through two flops
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            term_s1_q <= 8'h00;
            term_s2_q <= 8'h00;
        end
        else
        begin
            term_s1_q <= terminal_inputs;
            term_s2_q <= term_s1_q;
        end
    end

    // Per-bit source select, bit 0 is input 1
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            digital_inputs <= 8'h00;
        else
            digital_inputs <= (src_sel_q[7:0] & sw_in_q)
                | (~src_sel_q[7:0] & term_s2_q);
    end

    // Address in use loads at the first cycle after reset, or on node reset only while the address in use is nonzero
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            node_active_q <= 7'h00;
            node_boot_q <= 1'b1;
        end
        else
        begin
            node_boot_q <= 1'b0;
            // Address 0 is never left: a restart clears the setting, a node reset is blocked
            if (node_boot_q || (node_reset_cmd && node_active_q != 7'h00))
                node_active_q <= node_q[6:0];
        end
    end
    assign active_node_address = node_active_q;

    // Silence watchdog in whole seconds
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || link_evt.frame_valid || timeout_q == 16'h0000)
        begin
            sec_div_q <= 32'h0000_0000;
            sec_cnt_q <= 16'h0000;
        end
        else if (sec_div_q == 32'(SECOND_COUNT - 1))
        begin
            sec_div_q <= 32'h0000_0000;
            // Count stops at the limit so it can never wrap back
            if (!timeout_hit)
                sec_cnt_q <= sec_cnt_q + 16'h0001;
        end
        else
            sec_div_q <= sec_div_q + 32'h0000_0001;
    end
    assign timeout_hit = (timeout_q != 16'h0000)
        && (sec_cnt_q >= timeout_q);

    // Error alarm latched until reset
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            alarm_q <= 1'b0;
        else if (timeout_hit || comm_error_in)
            alarm_q <= 1'b1;
    end
    assign comm_error_alarm = alarm_q;
    // Only bit 0 of the reaction setting asks for a stop
    assign stop_request = alarm_q && (reaction_q[0] == 1'b1);

    // Reply delay sequencer
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rpl_q <= RPL_IDLE;
            tick_q <= 32'h0000_0000;
            units_q <= 16'h0000;
        end
        else
        begin
            // A request that ends while a reply is pending is ignored
            case (rpl_q)
                RPL_IDLE:
                begin
                    tick_q <= 32'h0000_0000;
                    units_q <= 16'h0000;
                    if (link_evt.request_end)
                        rpl_q <= RPL_WAIT;
                end
                RPL_WAIT:
                begin
                    if (units_q >= reply_dly_q)
                        rpl_q <= RPL_GO;
                    else if (tick_q == 32'(HALF_MS_COUNT - 1))
                    begin
                        tick_q <= 32'h0000_0000;
                        units_q <= units_q + 16'h0001;
                    end
                    else
                        tick_q <= tick_q + 32'h0000_0001;
                end
                RPL_GO:
                begin
                    // Wait here until the transmitter is free
                    if (link_evt.reply_ready)
                        rpl_q <= RPL_IDLE;
                end
                default:
                    rpl_q <= RPL_IDLE;
            endcase
        end
    end
    assign reply_start = (rpl_q == RPL_GO) && link_evt.reply_ready;

    // SYNC clock correction loop
    assign target_us = TARGET_BASE_US
        + 16'(TARGET_STEP_US * {12'h000, sync_cfg_q.target});
    assign late = sync_arrival_us > target_us;
    assign diff_us = late ? sync_arrival_us - target_us
        : target_us - sync_arrival_us;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            corr_q <= 5'sd0;
            locked_q <= 1'b0;
        end
        else if (sync_arrival_valid)
        begin
            locked_q <= diff_us
                < 16'(ERR_UNIT_US * {12'h000, sync_cfg_q.err_range});
            if (diff_us <= {12'h000, sync_cfg_q.dead_zone})
                corr_q <= corr_q;
            // Late samples pull the clock back, early ones push it on
            else if (late)
                corr_q <= -$signed({1'b0, sync_cfg_q.step});
            else
                corr_q <= $signed({1'b0, sync_cfg_q.step});
        end
    end
    assign clock_correction_us = corr_q;
    assign sync_locked = locked_q;

    // Profile enable and event gating
    assign profile_enable = profile_q[0];
    // A trigger passes only where its mask bit is set
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pdo_trigger[i] = mask_q[i] & pdo_event_src;
    end

    // Register read mux
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_req.rd)
        begin
            if (reg_req.addr == ADDR_REACTION)
                reg_rdata <= {16'h0000, reaction_q};
            else if (reg_req.addr == ADDR_TIMEOUT)
                reg_rdata <= {16'h0000, timeout_q};
            else if (reg_req.addr == ADDR_NODE)
                reg_rdata <= {16'h0000, node_q};
            else if (reg_req.addr == ADDR_SRC_SEL)
                reg_rdata <= {16'h0000, src_sel_q};
            else if (reg_req.addr == ADDR_REPLY_DLY)
                reg_rdata <= {16'h0000, reply_dly_q};
            else if (reg_req.addr == ADDR_SYNC_CFG)
                reg_rdata <= {16'h0000, sync_cfg_q};
            else if (reg_req.addr == ADDR_PROFILE_EN)
                reg_rdata <= {16'h0000, profile_q};
            else if (reg_req.addr == ADDR_STAT_W1)
                reg_rdata <= {16'h0000, stat_q[0]};
            else if (reg_req.addr == ADDR_STAT_W2)
                reg_rdata <= {16'h0000, stat_q[1]};
            else if (reg_req.addr == ADDR_STAT_W3)
                reg_rdata <= {16'h0000, stat_q[2]};
            else if (reg_req.addr == ADDR_STAT_W4)
                reg_rdata <= {16'h0000, stat_q[3]};
            else if (reg_req.addr == ADDR_CTRL_W1)
                reg_rdata <= {16'h0000, ctrl1_q};
            else if (reg_req.addr == ADDR_CTRL_W2)
                reg_rdata <= {16'h0000, ctrl2_q};
            else if (reg_req.addr == ADDR_CTRL_W3)
                reg_rdata <= ctrl3_q;
            else if (reg_req.addr == ADDR_MASK1)
                reg_rdata <= {28'h0000000, mask_q[0]};
            else if (reg_req.addr == ADDR_MASK2)
                reg_rdata <= {28'h0000000, mask_q[1]};
            else if (reg_req.addr == ADDR_MASK3)
                reg_rdata <= {28'h0000000, mask_q[2]};
            else if (reg_req.addr == ADDR_MASK4)
                reg_rdata <= {28'h0000000, mask_q[3]};
            else if (reg_req.addr == ADDR_SW_INPUT)
                reg_rdata <= {24'h000000, digital_inputs};
            // Unmapped addresses read as zero
            else
                reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

// ### testbench/comm_master_model.sv
`timescale 1ns/1ps
module comm_master_model (
    input wire logic frame_go, // Frame for this drive
    input wire logic req_go, // Request frame ends
    input wire logic ready_lvl, // Line free to answer
    output comm_cfg_pkg::link_evt_t link_evt // Events to the drive
);
    import comm_cfg_pkg::*;
    // A request is itself a frame; the line is busy while it ends
    assign link_evt = '{frame_valid: frame_go | req_go,
        request_end: req_go, reply_ready: ready_lvl & ~req_go};
endmodule

// ### testbench/comm_cfg_assertions.sv
`timescale 1ns/1ps
module comm_cfg_assertions (
    input wire logic clk_sys, // Clock
    input wire logic sys_rst, // Reset
    input wire comm_cfg_pkg::link_evt_t link_evt, // Link events
    input wire logic node_reset_cmd, // Node reset
    input wire logic sync_arrival_valid, // SYNC sample
    input wire logic [3:0] pdo_event_src, // Sources
    input wire logic [6:0] active_node_address, // Address
    input wire logic comm_error_alarm, // Alarm
    input wire logic stop_request, // Stop
    input wire logic reply_start, // Reply
    input wire logic signed [4:0] clock_correction_us, // Correction
    input wire logic sync_locked, // Locked
    input wire logic [3:0] pdo_trigger [4] // Triggers
);
    import comm_cfg_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    sequence s_sync_quiet;
        !sync_arrival_valid [*2];
    endsequence
    sequence s_node_quiet;
        !node_reset_cmd [*2];
    endsequence
    a_stop_needs_alarm: assert property (
        stop_request |-> comm_error_alarm) else $error("stop without alarm");
    a_alarm_held: assert property (
        comm_error_alarm |=> comm_error_alarm) else $error("alarm dropped");
    a_node_addr_held: assert property (
        s_node_quiet |=> $stable(active_node_address))
        else $error("address moved without node reset");
    a_trigger_masked: assert property (
        ((pdo_trigger[0] | pdo_trigger[1] | pdo_trigger[2] | pdo_trigger[3])
        & ~pdo_event_src) == 4'h0) else $error("trigger without source");
    a_reply_needs_ready: assert property (
        reply_start |-> link_evt.reply_ready) else $error("reply while busy");
    a_reply_single: assert property (
        reply_start |=> !reply_start) else $error("reply start too long");
    a_corr_quiet: assert property (
        s_sync_quiet |=> $stable(clock_correction_us))
        else $error("correction moved without sample");
    a_lock_quiet: assert property (
        s_sync_quiet |=> $stable(sync_locked))
        else $error("lock moved without sample");
endmodule
bind comm_supervision_config comm_cfg_assertions u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link_evt(link_evt),
    .node_reset_cmd(node_reset_cmd), .sync_arrival_valid(sync_arrival_valid),
    .pdo_event_src(pdo_event_src), .active_node_address(active_node_address),
    .comm_error_alarm(comm_error_alarm), .stop_request(stop_request),
    .reply_start(reply_start), .clock_correction_us(clock_correction_us),
    .sync_locked(sync_locked), .pdo_trigger(pdo_trigger));

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import comm_cfg_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_t reg_req = '0;
    logic node_reset_cmd = 1'b0;
    logic comm_error_in = 1'b0;
    logic [7:0] terminal_inputs = 8'h00;
    logic [15:0] sync_arrival_us = 16'h0000;
    logic sync_arrival_valid = 1'b0;
    logic [3:0] pdo_event_src = 4'h0;
    logic frame_go = 1'b0;
    logic req_go = 1'b0;
    logic ready_lvl = 1'b0;
    link_evt_t link_evt;
    logic [31:0] reg_rdata, x, y;
    logic [7:0] digital_inputs;
    logic [6:0] active_node_address;
    logic comm_error_alarm, stop_request, reply_start, sync_locked;
    logic profile_enable;
    logic signed [4:0] clock_correction_us;
    logic [3:0] pdo_trigger [4];
    logic [3:0] m [4];
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 79471;
    int ec, k, i;
    logic [31:0] sh [17];
    logic [11:0] ra [17] = '{12'h308, 12'h30A, 12'h30C, 12'h30E, 12'h312,
        12'h314, 12'h316, 12'h318, 12'h31A, 12'h31C, 12'h31E, 12'h320,
        12'h322, 12'h324, 12'h326, 12'h328, 12'h32A};
    logic [15:0] rv [17] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h5055, 16'h0,
        16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h1,
        16'h1, 16'hF};
    logic [31:0] wm [17] = '{32'h3F, 32'hFF, 32'hFF, 32'h7FF, 32'hFFFF,
        32'h1, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
        32'hFFFFFFFF, 32'hF, 32'hF, 32'hF, 32'hF};
    int ci [10] = '{0, 0, 1, 1, 3, 3, 4, 4, 4, 4};
    logic [31:0] cx [10] = '{32'h15, 32'h14, 32'h80, 32'h7F, 32'h3E9,
        32'h3E8, 32'h1000, 32'hA000, 32'h5A55, 32'h1001};
    logic [15:0] sa [7] = '{16'h190, 16'h196, 16'h195, 16'h18A, 16'h18B,
        16'h1C1, 16'h1C2};

    comm_supervision_config #(.SECOND_COUNT(100), .HALF_MS_COUNT(5))
    u_comm_supervision_config (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .link_evt(link_evt),
        .node_reset_cmd(node_reset_cmd), .comm_error_in(comm_error_in),
        .terminal_inputs(terminal_inputs), .sync_arrival_us(sync_arrival_us),
        .sync_arrival_valid(sync_arrival_valid),
        .pdo_event_src(pdo_event_src), .digital_inputs(digital_inputs),
        .active_node_address(active_node_address),
        .comm_error_alarm(comm_error_alarm), .stop_request(stop_request),
        .reply_start(reply_start), .clock_correction_us(clock_correction_us),
        .sync_locked(sync_locked), .profile_enable(profile_enable),
        .pdo_trigger(pdo_trigger));
    comm_master_model u_comm_master_model (.frame_go(frame_go),
        .req_go(req_go), .ready_lvl(ready_lvl), .link_evt(link_evt));

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_req <= '{1'b0, 1'b1, a, d};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_req <= '{1'b1, 1'b0, a, 32'h0};
        @(posedge clk_sys);
        reg_req <= '0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        cyc(4);
        sys_rst <= 1'b0;
        ec = 0;
        cyc(1);
    endtask
    // Value a register keeps after a write; out-of-range writes are dropped
    function automatic logic [31:0] acc(logic [11:0] a, logic [31:0] o,
        logic [31:0] d);
        case (a)
            12'h308: return d > 32'h14 ? o : d;
            12'h30A: return d > 32'h7F ? o : d;
            12'h30E: return d > 32'h3E8 ? o : d;
            12'h312: return (d < 32'h1001 || d > 32'h9FFF ||
                d[11:8] > 4'h9 || d[3:0] == 4'h0) ? o : d;
            default: return d;
        endcase
    endfunction
    task automatic reply_test(input int dl, input logic stall);
        int n;
        wr(12'h30E, dl);
        ready_lvl <= ~stall;
        req_go <= 1'b1;
        @(posedge clk_sys);
        req_go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while (reply_start !== 1'b1 && n < dl * 5 + 9);
        if (stall)
        begin
            chk(reply_start, 0);
            ready_lvl <= 1'b1;
            #1;
            chk(reply_start, 1);
        end
        else
            chk(n >= dl * 5 + 1 && n <= dl * 5 + 4, 1);
        @(posedge clk_sys);
        ready_lvl <= 1'b0;
    endtask
    task automatic sync_step(input int a, input logic [15:0] c);
        int df, dz, er, mm;
        @(posedge clk_sys);
        sync_arrival_us <= a[15:0];
        sync_arrival_valid <= 1'b1;
        @(posedge clk_sys);
        sync_arrival_valid <= 1'b0;
        cyc(2);
        #1;
        df = a - (400 + 10 * c[11:8]);
        dz = c[7:4];
        er = 10 * c[15:12];
        mm = c[3:0];
        if (df > dz || -df > dz)
            ec = df < 0 ? mm : -mm;
        chk(clock_correction_us, ec);
        chk(df < er && -df < er, sync_locked);
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #300000;
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        do_reset();
        for (i = 0; i < 17; i++)
            rc(ra[i], rv[i]);
        rc(12'h300, 32'h0);
        for (i = 0; i < 17; i++)
            sh[i] = rv[i];
        for (k = 0; k < 40; k++)
        begin
            i = k < 10 ? ci[k] : {$random(seed)} % 17;
            x = k < 10 ? cx[k] : $random(seed) & wm[i];
            wr(ra[i], x);
            sh[i] = acc(ra[i], sh[i], x);
            rc(ra[i], sh[i]);
        end
        do_reset();
        for (k = 0; k < 6; k++)
        begin
            x = $random(seed);
            wr(12'h30C, {24'h0, x[7:0]});
            wr(12'h40E, {24'h0, x[15:8]});
            terminal_inputs <= x[23:16];
            cyc(4);
            #1;
            y = (x[7:0] & x[15:8]) | (~x[7:0] & x[23:16]);
            chk(digital_inputs, y);
            rc(12'h40E, y);
        end
        for (k = 0; k < 8; k++)
        begin
            for (i = 0; i < 4; i++)
            begin
                m[i] = 4'($random(seed));
                wr(ra[13 + i], {28'h0, m[i]});
            end
            x = $random(seed);
            pdo_event_src <= x[3:0];
            cyc(1);
            #1;
            for (i = 0; i < 4; i++)
                chk(pdo_trigger[i], m[i] & x[3:0]);
        end
        for (i = 1; i >= 0; i--)
        begin
            wr(12'h314, i);
            cyc(1);
            #1;
            chk(profile_enable, i);
        end
        wr(12'h30A, 32'h5);
        @(posedge clk_sys);
        node_reset_cmd <= 1'b1;
        @(posedge clk_sys);
        node_reset_cmd <= 1'b0;
        cyc(3);
        #1;
        chk(active_node_address, 0);
        reply_test(0, 1'b0);
        reply_test(3, 1'b0);
        reply_test(1, 1'b1);
        reply_test(1000, 1'b0);
        wr(12'h308, 32'h0);
        cyc(400);
        #1;
        chk(comm_error_alarm, 0);
        wr(12'h306, 32'h0);
        wr(12'h308, 32'h2);
        repeat (4)
        begin
            @(posedge clk_sys);
            frame_go <= 1'b1;
            @(posedge clk_sys);
            frame_go <= 1'b0;
            cyc(150);
            #1;
            chk(comm_error_alarm, 0);
        end
        cyc(40);
        #1;
        chk(comm_error_alarm, 0);
        cyc(25);
        #1;
        chk(comm_error_alarm, 1);
        chk(stop_request, 0);
        wr(12'h306, 32'h1);
        cyc(1);
        #1;
        chk(stop_request, 1);
        do_reset();
        @(posedge clk_sys);
        comm_error_in <= 1'b1;
        @(posedge clk_sys);
        comm_error_in <= 1'b0;
        cyc(2);
        #1;
        chk(comm_error_alarm, 1);
        do_reset();
        for (k = 0; k < 7; k++)
            sync_step(sa[k], 16'h5055);
        // Target 490 us keeps a margin below the 500 us standard value
        wr(12'h312, 32'h3912);
        for (k = 0; k < 16; k++)
            sync_step(400 + {$random(seed)} % 140, 16'h3912);
        tally_and_finish();
    end
endmodule
